// ---- common/retimer_pkg.sv ----
// shared constants and types for the transmit bit retimer and its controller
package retimer_pkg;

    // system clock
    localparam int unsigned CLOCK_HZ       = 200_000_000;
    // reference clock and bit tick
    localparam int unsigned REF_CLOCK_HZ   = 3_579_545;
    localparam int unsigned BIT_TICK_HZ    = 1200;
    // bit tick period in system clocks, rounded down
    localparam int unsigned BIT_TICK_CYCLES = CLOCK_HZ / BIT_TICK_HZ;
    // reference tolerance in parts per thousand
    localparam int unsigned REF_TOL_PPT    = 1;
    // highest rate at which retiming may be used
    localparam int unsigned RETIME_MAX_BPS = 1212;
    // wake delay after sleep mode, in ms
    localparam int unsigned WAKE_DELAY_MS  = 20;
    localparam int unsigned WAKE_DELAY_CYCLES = CLOCK_HZ / 1000 * WAKE_DELAY_MS;
    // bit periods to hold data after leaving retiming
    localparam int unsigned EXIT_HOLD_BITS = 2;
    // strobe high width and data setup time before the strobe rises, used by the controller, in cycles
    localparam int unsigned STROBE_HIGH_CYCLES = 16;
    localparam int unsigned SETUP_CYCLES       = 4;

    // mode select encodings {mode_sel_hi, mode_sel_lo}
    localparam logic [1:0] MODE_TX_150  = 2'h0;
    localparam logic [1:0] MODE_TX_1200 = 2'h1;
    localparam logic [1:0] MODE_TX_5    = 2'h2;
    localparam logic [1:0] MODE_SLEEP   = 2'h3;

    // tone produced by the modulator
    typedef enum logic [2:0] {
        TONE_NONE,
        TONE_0HZ,
        TONE_387HZ,
        TONE_487HZ,
        TONE_1200HZ,
        TONE_2200HZ
    } tone_type;

endpackage

// ---- common/retimer_if.sv ----
// pins between the controller and the transmit retimer
`timescale 1ns/1ps
interface retimer_if;
    logic mode_sel_lo;
    logic mode_sel_hi;
    logic tx_data;
    logic strobe;
    logic bit_req_n;

    modport device (
        input  mode_sel_lo,
        input  mode_sel_hi,
        input  tx_data,
        input  strobe,
        output bit_req_n
    );

    modport host (
        output mode_sel_lo,
        output mode_sel_hi,
        output tx_data,
        output strobe,
        input  bit_req_n
    );
endinterface

// ---- hdl/bit_fifo.sv ----
// parameterised valid/ready fifo
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer arithmetic with wrap
    always_comb begin
        wr_next    = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1) : wr_reg;
        rd_next    = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1) : rd_reg;
        count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            count_reg <= '0;
        end else begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            count_reg <= count_next;
        end
    end

    // storage has no reset; only written entries are read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule

// ---- hdl/tx_retimer.sv ----
// device end: transmit bit retimer feeding the tone modulator
//
// Functional notes
// - retiming only in 1200bps mode, bit per strobe
// - controller never retimes above 1212bps
// - two one-bit registers in series
// - second register and strobe sample on tick
// - strobe high at tick: data passes straight
// - strobe low at tick: retimed, request asserted
// - high strobe clears the bit request
// - strobe rising edge loads first register
// - controller holds strobe low until request
// - controller gives bit then pulses strobe
// - data constant on entry until second bit
// - data held two bits after exit
// - strobe kept high when retiming unused
// - 5bps and 150bps modes always pass through
// - bit tick derived from reference clock; counted from the system clock here
// - two mode selects choose operating mode
// - 1200bps: zero 2200Hz, one 1200Hz
// - controller waits 20ms after sleep mode
`timescale 1ns/1ps
module tx_retimer
    import retimer_pkg::*;
#(
    // tick period in system clocks; a short value keeps test runs small
    parameter int unsigned TICK_CYCLES = BIT_TICK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    retimer_if.device        pins,
    output retimer_pkg::tone_type tone_out,
    output logic             mod_bit,
    output logic             sleep_mode,
    output logic             bit_tick
);
    import retimer_pkg::*;

    // ------------------------------------------------------------
    // bit tick
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_reg;
    logic [31:0] tick_cnt_next;
    logic        tick;

    // tick period from the system clock stands in for the reference divider
    always_comb begin
        tick          = (tick_cnt_reg == TICK_CYCLES - 1);
        tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // retiming datapath
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic       retime_mode;
    logic       strobe_d_reg;
    logic       first_reg;
    logic       first_next;
    logic       second_reg;
    logic       second_next;
    logic       retimed_reg;
    logic       retimed_next;
    logic       req_n_reg;
    logic       req_n_next;
    logic       mod_bit_next;
    logic       tick_reg;
    tone_type   tone_reg;
    tone_type   tone_next;

    assign mode        = {pins.mode_sel_hi, pins.mode_sel_lo};
    assign retime_mode = (mode == MODE_TX_1200);

    // next state of the two registers, retime flag and request
    always_comb begin
        first_next   = first_reg;
        second_next  = second_reg;
        retimed_next = retimed_reg;
        req_n_next   = req_n_reg;
        if (pins.strobe && !strobe_d_reg) begin
            first_next = pins.tx_data;
        end
        if (tick) begin
            second_next = first_reg;
            if (retime_mode && !pins.strobe) begin
                retimed_next = 1'b1;
                req_n_next   = 1'b0;
            end else begin
                retimed_next = 1'b0;
            end
        end
        // strobe high releases request, even on a tick
        if (pins.strobe || !retime_mode) begin
            req_n_next = 1'b1;
        end
        if (!retime_mode) begin
            retimed_next = 1'b0;
        end
    end

    // modulator bit and tone choice
    always_comb begin
        mod_bit_next = retimed_next ? second_next : pins.tx_data;
        unique case (mode)
            MODE_TX_1200: tone_next = mod_bit_next ? TONE_1200HZ : TONE_2200HZ;
            MODE_TX_150:  tone_next = mod_bit_next ? TONE_387HZ : TONE_487HZ;
            MODE_TX_5:    tone_next = mod_bit_next ? TONE_387HZ : TONE_0HZ;
            MODE_SLEEP:   tone_next = TONE_NONE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strobe_d_reg <= 1'b1;   // avoids false edge on strobe held high
            first_reg    <= 1'b0;
            second_reg   <= 1'b0;
            retimed_reg  <= 1'b0;
            req_n_reg    <= 1'b1;
            mod_bit      <= 1'b0;
            tone_reg     <= TONE_NONE;
            tick_reg     <= 1'b0;
            sleep_mode   <= 1'b1;
        end else begin
            strobe_d_reg <= pins.strobe;
            first_reg    <= first_next;
            second_reg   <= second_next;
            retimed_reg  <= retimed_next;
            req_n_reg    <= req_n_next;
            mod_bit      <= mod_bit_next;
            tone_reg     <= tone_next;
            tick_reg     <= tick;
            sleep_mode   <= (mode == MODE_SLEEP);
        end
    end

    assign pins.bit_req_n = req_n_reg;
    assign tone_out       = tone_reg;
    assign bit_tick       = tick_reg;
endmodule

// ---- hdl/retime_host.sv ----
// controller end: feeds buffered bits to the retimer, by strobe pulses when retiming and directly otherwise
`timescale 1ns/1ps
module retime_host
    import retimer_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = WAKE_DELAY_CYCLES,
    parameter int unsigned HOLD_CYCLES = EXIT_HOLD_BITS * BIT_TICK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    retimer_if.host          pins,
    input  wire logic [1:0]  mode_req,
    input  wire logic        retime_en,
    input  wire logic        bit_data,
    input  wire logic        bit_valid,
    output logic             bit_ready,
    output logic             busy
);
    import retimer_pkg::*;

    typedef enum {IDLE, WAKE, ENTER, WAIT_REQ, SETUP, HIGH, LOW, EXIT} state_type;

    logic      fifo_bit;
    logic      fifo_valid;
    logic      fifo_pop;
    state_type state_reg;
    state_type state_next;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic [1:0]  mode_reg;
    logic [1:0]  mode_next;
    logic        data_reg;
    logic        data_next;
    logic        strobe_reg;
    logic        strobe_next;

    // bits queue here so the producer is stalled while the link paces
    bit_fifo #(.WIDTH(1), .DEPTH(32)) queue (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (bit_data),
        .in_valid  (bit_valid),
        .in_ready  (bit_ready),
        .out_data  (fifo_bit),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        cnt_next    = (cnt_reg == 32'h0000_0000) ? cnt_reg : cnt_reg - 32'h0000_0001;
        mode_next   = mode_reg;
        data_next   = data_reg;
        strobe_next = strobe_reg;
        fifo_pop    = 1'b0;
        unique case (state_reg)
            IDLE: begin
                strobe_next = 1'b1;
                if (mode_req != mode_reg) begin
                    mode_next = mode_req;
                    if (mode_reg == MODE_SLEEP) begin
                        state_next = WAKE;
                        cnt_next   = WAKE_CYCLES;
                    end
                end else if (fifo_valid && mode_reg != MODE_SLEEP) begin
                    if (retime_en && mode_reg == MODE_TX_1200) begin
                        state_next = ENTER;
                    end else begin
                        data_next = fifo_bit;  // direct bits, producer sets pace
                        fifo_pop  = 1'b1;
                    end
                end
            end
            WAKE: begin
                if (cnt_reg == 32'h0000_0000) begin
                    state_next = IDLE;
                end
            end
            ENTER: begin
                strobe_next = 1'b0;  // data_reg held steady from here
                state_next  = WAIT_REQ;
            end
            WAIT_REQ: begin
                if (!pins.bit_req_n) begin
                    if (fifo_valid) begin
                        data_next  = fifo_bit;
                        fifo_pop   = 1'b1;
                        state_next = SETUP;
                        cnt_next   = SETUP_CYCLES;
                    end else begin
                        strobe_next = 1'b1;
                        state_next  = EXIT;
                        cnt_next    = HOLD_CYCLES;
                    end
                end
            end
            SETUP: begin
                if (cnt_reg == 32'h0000_0000) begin
                    strobe_next = 1'b1;
                    state_next  = HIGH;
                    cnt_next    = STROBE_HIGH_CYCLES;
                end
            end
            HIGH: begin
                if (cnt_reg == 32'h0000_0000) begin
                    strobe_next = 1'b0;
                    state_next  = LOW;
                end
            end
            LOW: begin
                // wait until the request clears before looking again
                if (pins.bit_req_n) begin
                    state_next = WAIT_REQ;
                end
            end
            EXIT: begin
                if (cnt_reg == 32'h0000_0000) begin
                    state_next = IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg  <= IDLE;
            cnt_reg    <= 32'h0000_0000;
            mode_reg   <= MODE_SLEEP;
            data_reg   <= 1'b1;
            strobe_reg <= 1'b1;
            busy       <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            mode_reg   <= mode_next;
            data_reg   <= data_next;
            strobe_reg <= strobe_next;
            busy       <= (state_next != IDLE);
        end
    end

    assign pins.mode_sel_lo = mode_reg[0];
    assign pins.mode_sel_hi = mode_reg[1];
    assign pins.tx_data     = data_reg;
    assign pins.strobe      = strobe_reg;
endmodule

// ---- verification/fsk_tx_bit_retimer_props.sv ----
// concurrent checks on the retimer link
`timescale 1ns/1ps
module fsk_tx_bit_retimer_props
    import retimer_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = BIT_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic mode_sel_lo,
    input wire logic mode_sel_hi,
    input wire logic tx_data,
    input wire logic strobe,
    input wire logic bit_req_n,
    input wire logic mod_bit,
    input wire logic bit_tick,
    input wire logic sleep_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [1:0]  mode;
    logic [17:0] gap_reg;
    logic [17:0] gap_next;
    logic        seen_reg;
    logic        seen_next;
    assign mode = {mode_sel_hi, mode_sel_lo};
    // ----------------------------------------
    // tick spacing counter
    // ----------------------------------------
    // first tick has no reference, so only later gaps are judged
    always_comb begin
        gap_next = bit_tick ? 18'h0 : gap_reg + 18'h1;
        seen_next = seen_reg | bit_tick;
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= 18'h0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            seen_reg <= seen_next;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_req_strobe_clear: assert property (strobe |=> bit_req_n)
        else $error("request low after a high strobe");
    chk_req_mode_off: assert property (mode != MODE_TX_1200 |=> bit_req_n)
        else $error("request low outside the 1200 mode");
    chk_req_on_tick: assert property ($fell(bit_req_n) |-> bit_tick && !$past(strobe))
        else $error("request fell without a tick and low strobe");
    chk_req_holds: assert property (!bit_req_n && !strobe && mode == MODE_TX_1200 |=> !bit_req_n)
        else $error("request dropped while strobe low");
    chk_pass_direct: assert property ((mode == MODE_TX_150 || mode == MODE_TX_5)
        |=> mod_bit == $past(tx_data))
        else $error("slow mode did not pass data through");
    chk_sleep_flag: assert property (1'b1 |=> sleep_mode == ($past(mode_sel_hi) && $past(mode_sel_lo)))
        else $error("sleep flag disagrees with mode");
    chk_tick_period: assert property (bit_tick && seen_reg |-> gap_reg == 18'(TICK_CYCLES - 1))
        else $error("bit tick spacing wrong");
    chk_strobe_setup: assert property ($rose(strobe) |-> $stable(tx_data))
        else $error("data moved with the strobe edge");
    chk_strobe_width: assert property ($rose(strobe) |-> strobe [*8])
        else $error("strobe pulse too short");
    chk_strobe_answers: assert property ($fell(bit_req_n) |-> ##[1:40] strobe)
        else $error("no strobe after a request");
endmodule

// ---- verification/fsk_tx_bit_retimer_test.sv ----
// self-checking bench for the host and retimer pair
`timescale 1ns/1ps
module fsk_tx_bit_retimer_test;
    import retimer_pkg::*;
    logic       clock;
    logic       resetn;
    logic [1:0] mode_req;
    logic       retime_en;
    logic       bit_data;
    logic       bit_valid;
    logic       bit_ready;
    logic       busy;
    tone_type   tone_out;
    logic       mod_bit;
    logic       sleep_mode;
    logic       bit_tick;
    logic       check_now;
    logic       armed;
    logic       expect_q[$];
    int         fail_count;
    int         tests_run;
    retimer_if link();
    // short tick so a whole buffer of retimed bits fits the cycle budget
    tx_retimer #(.TICK_CYCLES(200)) u_tx_retimer (.clock(clock), .resetn(resetn), .pins(link),
        .tone_out(tone_out), .mod_bit(mod_bit), .sleep_mode(sleep_mode), .bit_tick(bit_tick));
    // short wake; hold covers two of the shortened bit periods
    retime_host #(.WAKE_CYCLES(50), .HOLD_CYCLES(400)) u_retime_host (.clock(clock),
        .resetn(resetn), .pins(link), .mode_req(mode_req), .retime_en(retime_en),
        .bit_data(bit_data), .bit_valid(bit_valid), .bit_ready(bit_ready), .busy(busy));
    fsk_tx_bit_retimer_props #(.TICK_CYCLES(200)) u_props (.clock(clock), .resetn(resetn),
        .mode_sel_lo(link.mode_sel_lo), .mode_sel_hi(link.mode_sel_hi), .tx_data(link.tx_data),
        .strobe(link.strobe), .bit_req_n(link.bit_req_n), .mod_bit(mod_bit),
        .bit_tick(bit_tick), .sleep_mode(sleep_mode));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic compare(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // bounded wait: 0 request low, 1 strobe high, 2 notes used up, 3 data equals want, 4 idle
    task automatic wait_for(input int what, input int limit, input logic want);
        for (int i = 0; i < limit; i++) begin
            @(negedge clock);
            if ((what == 0 && link.bit_req_n === 1'b0) || (what == 1 && link.strobe === 1'b1)
                || (what == 2 && expect_q.size() == 0) || (what == 3 && link.tx_data === want)
                || (what == 4 && busy === 1'b0))
                return;
        end
        fail_count++;
        $display("unexpected hang at %0t in wait %0d", $time, what);
        end_of_test();
    endtask
    // valid stays up between calls so it never toggles within one step
    task automatic push(input logic b, output logic took);
        bit_data = b;
        bit_valid = 1'b1;
        took = bit_ready;
        @(negedge clock);
    endtask
    function automatic tone_type tone_of(input logic [1:0] m, input logic b);
        case (m)
            MODE_TX_150: return b ? TONE_387HZ : TONE_487HZ;
            MODE_TX_1200: return b ? TONE_1200HZ : TONE_2200HZ;
            MODE_TX_5: return b ? TONE_387HZ : TONE_0HZ;
            default: return TONE_NONE;
        endcase
    endfunction
    // one random bit straight through, retiming off
    task automatic send_pass(input logic [1:0] m);
        logic b;
        logic took;
        b = 1'($urandom_range(1, 0));
        push(b, took);
        bit_valid = 1'b0;
        expect_q.push_back(b);
        wait_for(3, 400, b);
        @(negedge clock);
        check_now = 1'b1;
        @(negedge clock);
        check_now = 1'b0;
        compare({5'h0, tone_out}, {5'h0, tone_of(m, b)});
        compare({7'h0, link.bit_req_n}, 8'h1);
    endtask
    // ----------------------------------------
    // clock and result watcher
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // sampled on the rising edge, before the design's updates land
    initial begin
        forever begin
            @(posedge clock);
            if (check_now || (armed && bit_tick === 1'b1)) begin
                armed = 1'b0;
                if (expect_q.size() == 0) begin
                    fail_count++;
                    $display("unexpected result at %0t with nothing noted", $time);
                end else begin
                    compare({7'h0, mod_bit}, {7'h0, expect_q.pop_front()});
                end
            end
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic took;
        int   cnt;
        resetn = 1'b0;
        mode_req = MODE_SLEEP;
        retime_en = 1'b0;
        bit_data = 1'b0;
        bit_valid = 1'b0;
        check_now = 1'b0;
        armed = 1'b0;
        fail_count = 0;
        tests_run = 0;
        void'($urandom(95250));
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        // every mode code, strobe left high
        for (int m = 0; m < 4; m++) begin
            mode_req = 2'(m);
            // let the host take the mode and finish any wake delay first
            repeat (2) @(negedge clock);
            wait_for(4, 1000, 1'b0);
            if (m == 3) begin
                repeat (4) @(negedge clock);
                compare({7'h0, sleep_mode}, 8'h1);
                compare({5'h0, tone_out}, {5'h0, TONE_NONE});
            end else begin
                repeat (4) send_pass(2'(m));
            end
        end
        // retimed: fill the buffer while the host sits in its wake delay from sleep
        mode_req = MODE_TX_1200;
        retime_en = 1'b1;
        cnt = 0;
        took = 1'b1;
        while (took && cnt < 40) begin
            push(1'b1, took);
            if (took) cnt++;
        end
        bit_valid = 1'b0;
        compare(8'(cnt), 8'h20);
        expect_q.push_back(1'b1);
        wait_for(0, 170000, 1'b0);
        compare({7'h0, link.strobe}, 8'h0);
        wait_for(1, 100, 1'b0);
        armed = 1'b1;
        wait_for(2, 170000, 1'b0);
        repeat (2) @(negedge clock);
        compare({5'h0, tone_out}, {5'h0, TONE_1200HZ});
        // leave retiming with bits still queued, then pass one through
        retime_en = 1'b0;
        mode_req = MODE_TX_150;
        // host drains the queued bits and its exit hold before it returns to idle
        wait_for(4, 20000, 1'b0);
        compare({7'h0, link.tx_data}, 8'h1);
        send_pass(MODE_TX_150);
        end_of_test();
    end
endmodule
